/* verilog/fcor_pkg.sv */
// Purpose: constants shared by the flash option register block
// Assumes: AHB-Lite register bus, 32-bit words, one clock
// Notes: offsets are byte addresses within the block
// Notes on behaviour
// - program select makes data-register writes program the main array
// - page wipe select erases the page holding the target address on start if its region is unprotected, else sets protect error
// - full wipe select erases the whole main array on start
// - option program select sends programming to the option byte area
// - option erase select erases the option byte area on start
// - start bit is set by software only and drops when busy drops, or at once when no erase can start
// - lock bit accepts only ones; locked after reset, control value 0x0000_0080
// - option programming only happens while option write enable is set
// - error enable raises the interrupt on program or protect error flags
// - completion enable raises the interrupt on the complete flag
// - writing forced reload reloads option bytes and pulses a system reset
// - address register holds the address used by the next operation
// - byte not matching its complement sets error and reads as 0xFF
// - read protection field reads 00, 01 or 1X for levels zero to two
// - watchdog select reads 0 hardware started, 1 software started
// - stop and standby reset bits read 0 when a reset is generated
// - option view takes user settings and two user data bytes from options
// - write protect view shows option bits, 0 means region protected
// - key sequence unlocks the controller; key register reads zero
// - busy flag stays set for the whole flash operation
// - complete flag is set when an operation finishes
// - program into a protected region sets protect error and is aborted
package fcor_pkg;

  // ***********************************************************
  // register offsets
  // ***********************************************************
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_CTRL2 = 8'h10;
  localparam logic [7:0] OFS_ADDR = 8'h14;
  localparam logic [7:0] OFS_PDATA = 8'h18;
  localparam logic [7:0] OFS_OBCS = 8'h1C;
  localparam logic [7:0] OFS_WRP = 8'h20;

  // ***********************************************************
  // control and status fields
  // ***********************************************************
  localparam int B_PG = 0;
  localparam int B_PWIPE = 1;
  localparam int B_FWIPE = 2;
  localparam int B_OBP = 4;
  localparam int B_OBE = 5;
  localparam int B_STA = 6;
  localparam int B_LOCK = 7;
  localparam int B_OPTION_WRITE_ENABLE = 9;
  localparam int B_ERROR_IRQ_ENABLE = 10;
  localparam int B_COMPLETION_IRQ_ENABLE = 12;
  localparam int B_RELOAD = 13;
  localparam int B_BUSY = 0;
  localparam int B_PEF = 2;
  localparam int B_WPEF = 4;
  localparam int B_OCF = 5;
  localparam logic [31:0] CTRL2_RESET = 32'h0000_0080;

  // ***********************************************************
  // option byte layout and view fields
  // ***********************************************************
  localparam int OPT_BYTES = 8;
  localparam int OB_RDP = 0;
  localparam int OB_USER = 1;
  localparam int OB_USER_BYTE_ZERO = 2;
  localparam int OB_USER_BYTE_ONE = 3;
  localparam int OB_WRP = 4;
  localparam int U_WDG = 0;
  localparam int U_STOP = 1;
  localparam int U_STDBY = 2;
  localparam int U_BOOT1 = 4;
  localparam int U_VMON = 5;
  localparam int U_PARITY = 6;
  localparam logic [7:0] RDP_LEVEL0 = 8'hAA;
  localparam logic [7:0] RDP_LEVEL2 = 8'hCC;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  localparam int WRP_SHIFT = 12;

  // ***********************************************************
  // unlock keys (values arbitrary) and flash commands
  // ***********************************************************
  localparam logic [31:0] KEY_FIRST = 32'h1357_2468;
  localparam logic [31:0] KEY_SECOND = 32'h8642_7531;
  localparam logic [2:0] CMD_PROG = 3'h1;
  localparam logic [2:0] CMD_PWIPE = 3'h2;
  localparam logic [2:0] CMD_FWIPE = 3'h3;
  localparam logic [2:0] CMD_OPROG = 3'h4;
  localparam logic [2:0] CMD_OWIPE = 3'h5;

  typedef enum logic [1:0] {
    FCOR_IDLE = 2'b01,
    FCOR_BUSY = 2'b10
  } fcor_seq_e;

endpackage

/* verilog/fcor_opt_store.sv */
// Purpose: holds loaded option bytes after complement check
// Assumes: raw bytes and complements are stable when load pulses
// Notes: read data come out of registers
`timescale 1ns/10ps
module fcor_opt_store (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [127:0] opt_raw,
  output logic [63:0] opt_q,
  output logic opt_err_q
);

  typedef struct packed {
    logic [63:0] bytes;
    logic err;
  } fcor_store_s;

  fcor_store_s s_q;
  fcor_store_s s_d;
  logic [7:0] bad;
  logic [63:0] checked;

  // ***********************************************************
  // per-byte complement check
  // ***********************************************************
  for (genvar i = 0; i < fcor_pkg::OPT_BYTES; i++)
  begin : g_byte
    assign bad[i] = (opt_raw[16*i +: 8] != ~opt_raw[16*i+8 +: 8]);
    assign checked[8*i +: 8] = bad[i] ? fcor_pkg::BYTE_ERASED : opt_raw[16*i +: 8];
  end

  always_comb
  begin
    s_d = s_q;
    if (load)
    begin
      s_d.bytes = checked;
      s_d.err = |bad;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign opt_q = s_q.bytes;
  assign opt_err_q = s_q.err;

endmodule

/* verilog/fcor_regs.sv */
// Purpose: flash controller control registers and operation sequencer
// Assumes: flash array answers on this clock with a done pulse
// Notes: every bus transfer takes one wait state
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/10ps
module fcor_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic fl_req,
  output logic [2:0] fl_cmd,
  output logic [31:0] fl_addr,
  output logic [15:0] fl_wdata,
  input wire logic fl_done,
  input wire logic fl_prog_err,
  input wire logic [127:0] opt_raw,
  output logic flash_irq,
  output logic sys_reset_req
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    fcor_pkg::fcor_seq_e seq;
    logic lock;
    logic key_half;
    logic program_select;
    logic page_wipe_select;
    logic full_wipe_select;
    logic option_program_select;
    logic option_erase_or_error;
    logic operation_start;
    logic option_write_enable;
    logic error_irq_enable;
    logic completion_irq_enable;
    logic busy_flag;
    logic program_error_flag;
    logic protect_error_flag;
    logic operation_complete_flag;
    logic [31:0] addr;
    logic booted;
    logic reload;
    logic ap_pend;
    logic ap_write;
    logic [7:0] ap_addr;
    logic ready;
    logic [31:0] rdata;
    logic req;
    logic [2:0] cmd;
    logic [15:0] wdata;
    logic irq;
    logic sys_rst;
  } fcor_state_s;

  fcor_state_s s_q;
  fcor_state_s s_d;
  logic [63:0] opt_q;
  logic opt_err_q;
  logic [7:0] user_b;
  logic [31:0] wrp;
  logic [1:0] rdp_level;
  logic [31:0] obcs_view;
  logic region_open;

  // ***********************************************************
  // option byte store
  // ***********************************************************
  fcor_opt_store u_store (
    .clk(clk),
    .rst_b(rst_b),
    .load(s_q.reload | ~s_q.booted),
    .opt_raw(opt_raw),
    .opt_q(opt_q),
    .opt_err_q(opt_err_q)
  );

  assign user_b = opt_q[8*fcor_pkg::OB_USER +: 8];
  assign wrp = opt_q[8*fcor_pkg::OB_WRP +: 32];
  assign region_open = wrp[s_q.addr[fcor_pkg::WRP_SHIFT +: 5]];

  always_comb
  begin
    if (opt_q[8*fcor_pkg::OB_RDP +: 8] == fcor_pkg::RDP_LEVEL0)
      rdp_level = 2'h0;
    else if (opt_q[8*fcor_pkg::OB_RDP +: 8] == fcor_pkg::RDP_LEVEL2)
      rdp_level = 2'h2;
    else
      rdp_level = 2'h1;
  end

  // view layout: user bits, two data bytes, load error
  always_comb
  begin
    obcs_view = '0;
    obcs_view[0] = opt_err_q;
    obcs_view[2:1] = rdp_level;
    obcs_view[8] = user_b[fcor_pkg::U_WDG];
    obcs_view[9] = user_b[fcor_pkg::U_STOP];
    obcs_view[10] = user_b[fcor_pkg::U_STDBY];
    obcs_view[12] = user_b[fcor_pkg::U_BOOT1];
    obcs_view[13] = user_b[fcor_pkg::U_VMON];
    obcs_view[14] = user_b[fcor_pkg::U_PARITY];
    obcs_view[23:16] = opt_q[8*fcor_pkg::OB_USER_BYTE_ZERO +: 8];
    obcs_view[31:24] = opt_q[8*fcor_pkg::OB_USER_BYTE_ONE +: 8];
  end

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb
  begin
    logic wr;
    logic unlocked;
    logic idle;
    logic [31:0] d;
    wr = s_q.ap_pend & s_q.ap_write;
    unlocked = ~s_q.lock;
    idle = (s_q.seq == fcor_pkg::FCOR_IDLE);
    d = hwdata;
    s_d = s_q;
    s_d.req = 1'b0;
    s_d.sys_rst = 1'b0;
    s_d.reload = 1'b0;
    s_d.booted = 1'b1;

    // bus data phase
    if (s_q.ap_pend)
    begin
      s_d.ap_pend = 1'b0;
      s_d.ready = 1'b1;
      s_d.rdata = '0;
      if (!s_q.ap_write)
      begin
        unique case (s_q.ap_addr)
          fcor_pkg::OFS_STATUS:
          begin
            s_d.rdata[fcor_pkg::B_BUSY] = s_q.busy_flag;
            s_d.rdata[fcor_pkg::B_PEF] = s_q.program_error_flag;
            s_d.rdata[fcor_pkg::B_WPEF] = s_q.protect_error_flag;
            s_d.rdata[fcor_pkg::B_OCF] = s_q.operation_complete_flag;
          end
          fcor_pkg::OFS_CTRL2:
          begin
            s_d.rdata[fcor_pkg::B_PG] = s_q.program_select;
            s_d.rdata[fcor_pkg::B_PWIPE] = s_q.page_wipe_select;
            s_d.rdata[fcor_pkg::B_FWIPE] = s_q.full_wipe_select;
            s_d.rdata[fcor_pkg::B_OBP] = s_q.option_program_select;
            s_d.rdata[fcor_pkg::B_OBE] = s_q.option_erase_or_error;
            s_d.rdata[fcor_pkg::B_STA] = s_q.operation_start;
            s_d.rdata[fcor_pkg::B_LOCK] = s_q.lock;
            s_d.rdata[fcor_pkg::B_OPTION_WRITE_ENABLE] = s_q.option_write_enable;
            s_d.rdata[fcor_pkg::B_ERROR_IRQ_ENABLE] = s_q.error_irq_enable;
            s_d.rdata[fcor_pkg::B_COMPLETION_IRQ_ENABLE] = s_q.completion_irq_enable;
          end
          fcor_pkg::OFS_OBCS: s_d.rdata = obcs_view;
          fcor_pkg::OFS_WRP: s_d.rdata = wrp;
          default: s_d.rdata = '0;
        endcase
      end
    end

    // key sequence
    if (wr && s_q.ap_addr == fcor_pkg::OFS_KEY && s_q.lock)
    begin
      if (!s_q.key_half && d == fcor_pkg::KEY_FIRST)
        s_d.key_half = 1'b1;
      else if (s_q.key_half && d == fcor_pkg::KEY_SECOND)
      begin
        s_d.lock = 1'b0;
        s_d.key_half = 1'b0;
      end
      else
        s_d.key_half = 1'b0;
    end

    // status flags clear on write of one
    if (wr && s_q.ap_addr == fcor_pkg::OFS_STATUS)
    begin
      if (d[fcor_pkg::B_PEF])
        s_d.program_error_flag = 1'b0;
      if (d[fcor_pkg::B_WPEF])
        s_d.protect_error_flag = 1'b0;
      if (d[fcor_pkg::B_OCF])
        s_d.operation_complete_flag = 1'b0;
    end

    // control register, ignored while locked
    if (wr && s_q.ap_addr == fcor_pkg::OFS_CTRL2 && unlocked)
    begin
      s_d.program_select = d[fcor_pkg::B_PG];
      s_d.page_wipe_select = d[fcor_pkg::B_PWIPE];
      s_d.full_wipe_select = d[fcor_pkg::B_FWIPE];
      s_d.option_program_select = d[fcor_pkg::B_OBP];
      s_d.option_erase_or_error = d[fcor_pkg::B_OBE];
      s_d.operation_start = s_q.operation_start | d[fcor_pkg::B_STA];
      s_d.lock = d[fcor_pkg::B_LOCK];
      s_d.option_write_enable = d[fcor_pkg::B_OPTION_WRITE_ENABLE];
      s_d.error_irq_enable = d[fcor_pkg::B_ERROR_IRQ_ENABLE];
      s_d.completion_irq_enable = d[fcor_pkg::B_COMPLETION_IRQ_ENABLE];
      if (d[fcor_pkg::B_RELOAD])
      begin
        s_d.reload = 1'b1;
        s_d.sys_rst = 1'b1;
      end
    end

    // address register, held steady during an operation
    if (wr && s_q.ap_addr == fcor_pkg::OFS_ADDR && unlocked && !s_q.busy_flag)
      s_d.addr = d;

    // programming data write launches a program
    if (wr && s_q.ap_addr == fcor_pkg::OFS_PDATA && unlocked && idle)
    begin
      if (s_q.option_program_select)
      begin
        if (s_q.option_write_enable)
        begin
          s_d.req = 1'b1;
          s_d.cmd = fcor_pkg::CMD_OPROG;
          s_d.wdata = d[15:0];
          s_d.busy_flag = 1'b1;
          s_d.seq = fcor_pkg::FCOR_BUSY;
        end
      end
      else if (s_q.program_select)
      begin
        if (!region_open)
          s_d.protect_error_flag = 1'b1;
        else
        begin
          s_d.req = 1'b1;
          s_d.cmd = fcor_pkg::CMD_PROG;
          s_d.wdata = d[15:0];
          s_d.busy_flag = 1'b1;
          s_d.seq = fcor_pkg::FCOR_BUSY;
        end
      end
    end

    // ***********************************************************
    // sequencer
    // ***********************************************************
    unique case (s_q.seq)
      fcor_pkg::FCOR_IDLE:
      begin
        if (s_q.operation_start)
        begin
          s_d.wdata = '0;
          if (s_q.full_wipe_select)
          begin
            s_d.req = 1'b1;
            s_d.cmd = fcor_pkg::CMD_FWIPE;
          end
          else if (s_q.page_wipe_select && region_open)
          begin
            s_d.req = 1'b1;
            s_d.cmd = fcor_pkg::CMD_PWIPE;
          end
          else if (s_q.option_erase_or_error)
          begin
            s_d.req = 1'b1;
            s_d.cmd = fcor_pkg::CMD_OWIPE;
          end
          if (s_d.req)
          begin
            s_d.busy_flag = 1'b1;
            s_d.seq = fcor_pkg::FCOR_BUSY;
          end
          else
          begin
            s_d.operation_start = 1'b0;
            if (s_q.page_wipe_select)
              s_d.protect_error_flag = 1'b1;
          end
        end
      end
      fcor_pkg::FCOR_BUSY:
      begin
        if (fl_done)
        begin
          s_d.busy_flag = 1'b0;
          s_d.operation_start = 1'b0;
          s_d.operation_complete_flag = 1'b1;
          if (fl_prog_err)
            s_d.program_error_flag = 1'b1;
          s_d.seq = fcor_pkg::FCOR_IDLE;
        end
      end
      default: s_d.seq = fcor_pkg::FCOR_IDLE;
    endcase

    // bus address phase
    if (hsel && htrans[1] && hready)
    begin
      s_d.ap_pend = 1'b1;
      s_d.ap_write = hwrite;
      s_d.ap_addr = (haddr[1:0] == 2'h0 && hsize == 3'h2) ? haddr[7:0] : 8'hFF;
      s_d.ready = 1'b0;
    end

    s_d.irq = (s_q.error_irq_enable &
              (s_q.program_error_flag | s_q.protect_error_flag)) |
              (s_q.completion_irq_enable & s_q.operation_complete_flag);
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
      s_q.seq <= fcor_pkg::FCOR_IDLE;
      s_q.lock <= fcor_pkg::CTRL2_RESET[fcor_pkg::B_LOCK];
      s_q.ready <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign hreadyout = s_q.ready;
  assign hresp = s_q.sys_rst & 1'b0;
  assign hrdata = s_q.rdata;
  assign fl_req = s_q.req;
  assign fl_cmd = s_q.cmd;
  assign fl_addr = s_q.addr;
  assign fl_wdata = s_q.wdata;
  assign flash_irq = s_q.irq;
  assign sys_reset_req = s_q.sys_rst;

endmodule

/* verif/fcor_checker.sv */
// Purpose: timing checks on the bus and flash ports of fcor_regs
// Assumes: hready is fed back from hreadyout
// Notes: bound into every fcor_regs instance
`timescale 1ns/10ps
module fcor_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic fl_req,
  input wire logic [2:0] fl_cmd,
  input wire logic [31:0] fl_addr,
  input wire logic fl_done,
  input wire logic sys_reset_req
);
  // ******************************
  // helper state
  // ******************************
  logic busy_q, busy_d, zr_q, zr_d, take, zofs;
  assign take = hsel && htrans[1] && hready;
  assign zofs = haddr[7:0] == fcor_pkg::OFS_KEY || haddr[7:0] == fcor_pkg::OFS_ADDR ||
    haddr[7:0] == fcor_pkg::OFS_PDATA;
  always_comb
  begin
    busy_d = fl_req ? 1'b1 : (fl_done ? 1'b0 : busy_q);
    zr_d = (take && !hwrite) ? zofs : (hreadyout ? 1'b0 : zr_q);
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_q <= 1'b0;
      zr_q <= 1'b0;
    end
    else
    begin
      busy_q <= busy_d;
      zr_q <= zr_d;
    end
  end
  // ******************************
  // assertions
  // ******************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  a_wait_state: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("wait state not exactly one cycle");
  a_zero_reads: assert property (hreadyout && zr_q |-> hrdata == 32'h0)
    else $error("write-only register read not zero");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data changed outside a transfer");
  a_req_pulse: assert property (fl_req |=> !fl_req)
    else $error("flash request longer than one cycle");
  a_single_op: assert property (fl_req |-> !busy_q)
    else $error("flash request while busy");
  a_cmd_legal: assert property (fl_req |-> fl_cmd >= 3'h1 && fl_cmd <= 3'h5)
    else $error("flash command out of range");
  a_cmd_steady: assert property (busy_q && !fl_done |->
    $stable(fl_cmd) && $stable(fl_addr))
    else $error("flash command or address moved while busy");
  a_reload_pulse: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("system reset request longer than one cycle");
endmodule
bind fcor_regs fcor_checker u_chk (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .fl_req(fl_req), .fl_cmd(fl_cmd), .fl_addr(fl_addr), .fl_done(fl_done),
  .sys_reset_req(sys_reset_req));

/* verif/fcor_flash_model.sv */
// Purpose: flash array stand-in answering requests after a delay
// Assumes: one request at a time
// Notes: error line toggles except in the done cycle
`timescale 1ns/10ps
module fcor_flash_model #(parameter int DLY = 6) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic fl_req,
  input wire logic [2:0] fl_cmd,
  input wire logic [31:0] fl_addr,
  input wire logic [15:0] fl_wdata,
  input wire logic perr,
  output logic fl_done,
  output logic fl_prog_err,
  output logic [2:0] last_cmd,
  output logic [31:0] last_addr,
  output logic [15:0] last_wdata,
  output int reqs
);
  int cnt;
  logic tog = 1'b0;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= 0;
      reqs <= 0;
    end
    else if (fl_req)
    begin
      cnt <= DLY;
      reqs <= reqs + 1;
      last_cmd <= fl_cmd;
      last_addr <= fl_addr;
      last_wdata <= fl_wdata;
    end
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  always_ff @(posedge clk)
    tog <= ~tog;
  assign fl_done = (cnt == 1);
  assign fl_prog_err = fl_done ? perr : tog;
endmodule

/* verif/flash_ctrl_option_regs_tb.sv */
// Purpose: register-level tests of fcor_regs over AHB-Lite
// Assumes: flash model answers six cycles after a request
// Notes: hready is the slave's hreadyout
`timescale 1ns/10ps
module flash_ctrl_option_regs_tb;
  logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, perr = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, fl_addr, l_addr, tmp;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'h2, fl_cmd, l_cmd;
  logic [15:0] fl_wdata, l_wdata;
  logic [127:0] opt_raw;
  logic hready, hreadyout, hresp, fl_req, fl_done, fl_prog_err, flash_irq, sys_reset_req;
  int fails = 0, cmp_count = 0, reqs, rst_cnt = 0;
  logic [31:0] sel [3] = '{32'h2, 32'h4, 32'h20};
  logic [2:0] cmd [3] = '{fcor_pkg::CMD_PWIPE, fcor_pkg::CMD_FWIPE, fcor_pkg::CMD_OWIPE};
  logic [7:0] lvb [3] = '{8'hAA, 8'h12, 8'hCC};
  function automatic logic [15:0] ob(input logic [7:0] v);
    return {~v, v};
  endfunction
  assign hready = hreadyout;
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
    if (sys_reset_req === 1'b1)
      rst_cnt++;
  fcor_regs DUT (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .fl_req(fl_req), .fl_cmd(fl_cmd), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_done(fl_done), .fl_prog_err(fl_prog_err), .opt_raw(opt_raw),
    .flash_irq(flash_irq), .sys_reset_req(sys_reset_req));
  fcor_flash_model u_fl (.clk(clk), .rst_b(rst_b), .fl_req(fl_req), .fl_cmd(fl_cmd),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata), .perr(perr), .fl_done(fl_done),
    .fl_prog_err(fl_prog_err), .last_cmd(l_cmd), .last_addr(l_addr), .last_wdata(l_wdata),
    .reqs(reqs));
  // ******************************
  // shared tasks
  // ******************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
    begin
      fails++;
      test_done();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    tmp = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, tmp, exp);
  endtask
  task automatic unlock();
    wr(fcor_pkg::OFS_KEY, fcor_pkg::KEY_FIRST);
    wr(fcor_pkg::OFS_KEY, fcor_pkg::KEY_SECOND);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, fcor_pkg::OFS_STATUS, 32'h0);
      n++;
    end
    while (tmp[0] !== 1'b0 && n < 30);
    if (tmp[0] !== 1'b0)
    begin
      fails++;
      test_done();
    end
  endtask
  // ******************************
  // main sequence
  // ******************************
  initial
  begin
    opt_raw <= {ob(8'hFF), ob(8'hFF), ob(8'hFF), ob(8'hFE), 16'hA5A5, ob(8'h5A),
      ob(8'h45), ob(8'hCC)};
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc("ctrl2", fcor_pkg::OFS_CTRL2, 32'h80);
    rdc("addr", fcor_pkg::OFS_ADDR, 32'h0);
    rdc("key", fcor_pkg::OFS_KEY, 32'h0);
    rdc("pdata", fcor_pkg::OFS_PDATA, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    rdc("obcs", fcor_pkg::OFS_OBCS, 32'hFF5A_4505);
    rdc("wrp", fcor_pkg::OFS_WRP, 32'hFFFF_FFFE);
    wr(fcor_pkg::OFS_CTRL2, 32'h1);
    rdc("ctrl2 locked", fcor_pkg::OFS_CTRL2, 32'h80);
    unlock();
    rdc("ctrl2 open", fcor_pkg::OFS_CTRL2, 32'h0);
    wr(fcor_pkg::OFS_CTRL2, 32'h80);
    wr(fcor_pkg::OFS_CTRL2, 32'h0);
    rdc("relock", fcor_pkg::OFS_CTRL2, 32'h80);
    unlock();
    $display("test lock done");
    wr(fcor_pkg::OFS_CTRL2, 32'h1);
    wr(fcor_pkg::OFS_ADDR, 32'h0000_0004);
    wr(fcor_pkg::OFS_PDATA, 32'h1234);
    rdc("status wpef", fcor_pkg::OFS_STATUS, 32'h10);
    chk("reqs aborted", reqs, 0);
    chk("irq off", flash_irq, 1'b0);
    wr(fcor_pkg::OFS_STATUS, 32'h10);
    wr(fcor_pkg::OFS_CTRL2, 32'h1401);
    wr(fcor_pkg::OFS_ADDR, 32'h0000_3004);
    wr(fcor_pkg::OFS_PDATA, 32'hBEEF);
    wr(fcor_pkg::OFS_PDATA, 32'hDEAD);
    rdc("status busy", fcor_pkg::OFS_STATUS, 32'h1);
    wait_idle();
    rdc("status ocf", fcor_pkg::OFS_STATUS, 32'h20);
    chk("irq ocf", flash_irq, 1'b1);
    chk("prog cmd", {29'h0, l_cmd}, {29'h0, fcor_pkg::CMD_PROG});
    chk("prog addr", l_addr, 32'h3004);
    chk("prog data", {16'h0, l_wdata}, 32'hBEEF);
    wr(fcor_pkg::OFS_STATUS, 32'h20);
    rdc("status clr", fcor_pkg::OFS_STATUS, 32'h0);
    chk("irq clr", flash_irq, 1'b0);
    $display("test program done");
    wr(fcor_pkg::OFS_ADDR, 32'h0000_3000);
    for (int i = 0; i < 3; i++)
    begin
      wr(fcor_pkg::OFS_CTRL2, sel[i] | 32'h40);
      rdc("sta held", fcor_pkg::OFS_CTRL2, sel[i] | 32'h40);
      wait_idle();
      rdc("sta clr", fcor_pkg::OFS_CTRL2, sel[i]);
      chk("wipe cmd", {29'h0, l_cmd}, {29'h0, cmd[i]});
      chk("wipe addr", fl_addr, 32'h3000);
    end
    wr(fcor_pkg::OFS_CTRL2, 32'h10);
    wr(fcor_pkg::OFS_PDATA, 32'h55);
    repeat (2) @(posedge clk);
    chk("oprog blocked", reqs, 4);
    wr(fcor_pkg::OFS_CTRL2, 32'h610);
    perr <= 1'b1;
    wr(fcor_pkg::OFS_PDATA, 32'h55);
    wait_idle();
    perr <= 1'b0;
    chk("oprog cmd", {29'h0, l_cmd}, {29'h0, fcor_pkg::CMD_OPROG});
    rdc("status pef", fcor_pkg::OFS_STATUS, 32'h24);
    chk("irq err", flash_irq, 1'b1);
    wr(fcor_pkg::OFS_STATUS, 32'h24);
    $display("test erase done");
    for (int i = 0; i < 3; i++)
    begin
      opt_raw[15:0] <= ob(lvb[i]);
      wr(fcor_pkg::OFS_CTRL2, 32'h2000);
      rdc("reload", fcor_pkg::OFS_OBCS, 32'hFF5A_4501 | (i << 1));
    end
    chk("reset pulses", rst_cnt, 3);
    $display("test reload done");
    test_done();
  end
endmodule
